// >>> src/cbt_core.sv
// cbt_core: bit timing, listen-only loopback and power modes of a can
// controller, with an axi4-lite register slave.
// assumes aclk is the bus clock; osc_clk, can_rx, cpu_wait, cpu_stop
// are asynchronous pins. the protocol logic sits on the user ports.
`timescale 1ns/1ps
module cbt_core
   import cbt_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              osc_clk,
   input  wire logic              cpu_wait,
   input  wire logic              cpu_stop,
   input  wire logic              can_rx,
   output logic                   transmit_pin,
   input  wire logic              tx_data,
   input  wire logic              frame_active,
   output logic                   rx_bit,
   output logic                   rx_bit_strobe,
   output logic                   tx_point,
   output logic                   wakeup_irq,
   output cbt_mode_e              mode
);
   if (ADDR_W < 5) begin : g_addr_chk
      $error("ADDR_W too small for register map");
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage read only by second stage
   logic [1:0] osc_s;
   logic       osc_q;
   logic [1:0] rx_s;
   logic [1:0] wait_s;
   logic [1:0] stop_s;
   logic [1:0] slp_s;
   logic [1:0] csw_s;
   logic [3:0] ctrl0;
   logic [2:0] ctrl1;
   logic [7:0] btr0;
   logic [7:0] btr1;
   logic       ena_locked;
   logic       sleep_ack;
   logic       wake_flag;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_s  <= 2'h0;
         osc_q  <= 1'b0;
         rx_s   <= 2'h3;
         wait_s <= 2'h0;
         stop_s <= 2'h0;
      end else begin
         osc_s  <= {osc_s[0], osc_clk};
         osc_q  <= osc_s[1];
         rx_s   <= {rx_s[0], can_rx};
         wait_s <= {wait_s[0], cpu_wait};
         stop_s <= {stop_s[0], cpu_stop};
      end
   end

   // sleep request and stop-in-wait bits cross into protocol side through two stages
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slp_s <= 2'h0;
         csw_s <= 2'h0;
      end else begin
         slp_s <= {slp_s[0], ctrl0[C0_SLEEP_REQUEST]};
         csw_s <= {csw_s[0], ctrl0[C0_STOP_IN_WAIT]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mode selection
   logic pwrdn_req;
   logic run;
   logic rx_eff;
   logic osc_rise;
   assign pwrdn_req = stop_s[1] | (wait_s[1] & csw_s[1]);
   assign run       = (mode == CBT_NORMAL);
   assign osc_rise  = osc_s[1] & ~osc_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode <= CBT_DISABLED;
      end else if (!ctrl1[C1_ENA]) begin
         mode <= CBT_DISABLED;
      end else if (pwrdn_req) begin
         mode <= CBT_PWRDN;
      end else begin
         case (mode)
            CBT_PWRDN:    mode <= CBT_NORMAL;
            CBT_DISABLED: mode <= CBT_NORMAL;
            CBT_NORMAL:   mode <= sleep_ack ? CBT_SLEEP : CBT_NORMAL;
            CBT_SLEEP:    mode <= sleep_ack ? CBT_SLEEP : CBT_NORMAL;
            default:      mode <= CBT_DISABLED;
         endcase
      end
   end

   // sleep handshake: ack only once no frame is in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_ack <= 1'b0;
      end else if (mode == CBT_PWRDN || mode == CBT_DISABLED) begin
         sleep_ack <= 1'b0;
      end else if (!slp_s[1]) begin
         sleep_ack <= 1'b0;
      end else if (!frame_active) begin
         sleep_ack <= 1'b1;
      end
   end

   // wake event: dominant bus in sleep with wake enabled; set beats clear
   logic wake_hit;
   logic wake_clr;
   assign wake_hit = (mode == CBT_SLEEP) && ctrl0[C0_SLEEP_REQUEST] && sleep_ack
                     && ctrl0[C0_WAKEUP_ENABLE] && !rx_s[1];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_flag <= 1'b0;
      end else if (wake_hit) begin
         wake_flag <= 1'b1;
      end else if (wake_clr) begin
         wake_flag <= 1'b0;
      end
   end

   // interrupt pulse of one cycle, registered from a wake hit while asleep with both enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wakeup_irq <= 1'b0;
      end else begin
         wakeup_irq <= wake_hit & ctrl0[C0_WAKEUP_IRQ_ENABLE];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // quantum generator; clock stop is modelled as a halted engine
   logic [B0_PRE_W-1:0] pre_cnt;
   logic                pclk_tick;
   logic                tq;
   assign pclk_tick = ctrl1[C1_CLKS] | osc_rise;
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         pre_cnt <= '0;
         tq      <= 1'b0;
      end else if (pclk_tick) begin
         if (pre_cnt == btr0[B0_PRE +: B0_PRE_W]) begin
            pre_cnt <= '0;
            tq      <= 1'b1;
         end else begin
            pre_cnt <= pre_cnt + 1'b1;
            tq      <= 1'b0;
         end
      end else begin
         tq <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bit time engine
   cbt_seg_e   seg;
   logic [4:0] qcnt;
   logic [4:0] seg1_len;
   logic [3:0] seg2_len;
   logic [2:0] sjw_len;
   logic [2:0] hist;
   logic       rx_prev;
   logic       edge_dom;
   logic       maj;
   assign seg1_len = {1'b0, btr1[B1_SEG1 +: 4]} + 5'h01;
   assign seg2_len = {1'b0, btr1[B1_SEG2 +: 3]} + 4'h1;
   assign sjw_len  = {1'b0, btr0[B0_SJW +: 2]} + 3'h1;
   assign edge_dom = rx_prev & ~rx_eff;
   assign maj = btr1[B1_SAMP3]
              ? ((hist[1] & hist[0]) | (hist[1] & rx_eff) | (hist[0] & rx_eff))
              : rx_eff;
   // listen-only loops sent dominant bits back; sleep without wake masks bus
   assign rx_eff = (mode == CBT_SLEEP && !ctrl0[C0_WAKEUP_ENABLE]) ? 1'b1
                 : rx_s[1] & (ctrl1[C1_LISTN] ? tx_data : 1'b1);

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         seg     <= SEG_SYNC;
         qcnt    <= 5'h00;
         hist    <= 3'h7;
         rx_prev <= 1'b1;
      end else if (tq) begin
         rx_prev <= rx_eff;
         hist    <= {hist[1:0], rx_eff};
         case (seg)
            SEG_SYNC: begin
               seg  <= SEG_ONE;
               qcnt <= 5'h00;
            end
            SEG_ONE: begin
               if (edge_dom && qcnt != 5'h00 && qcnt <= {2'h0, sjw_len}) begin
                  qcnt <= 5'h00; // late edge: stretch segment one
               end else if (qcnt == seg1_len - 5'h01) begin
                  seg  <= SEG_TWO;
                  qcnt <= 5'h00;
               end else begin
                  qcnt <= qcnt + 5'h01;
               end
            end
            SEG_TWO: begin
               if (edge_dom && ({1'b0, seg2_len} - qcnt) <= {2'h0, sjw_len}) begin
                  seg  <= SEG_ONE; // early edge restarts bit
                  qcnt <= 5'h00;
               end else if (qcnt == {1'b0, seg2_len} - 5'h01) begin
                  seg  <= SEG_SYNC;
                  qcnt <= 5'h00;
               end else begin
                  qcnt <= qcnt + 5'h01;
               end
            end
            default: begin
               seg  <= SEG_SYNC;
               qcnt <= 5'h00;
            end
         endcase
      end
   end

   // sample point closes segment one, transmit point opens the bit
   logic samp_now;
   logic tx_now;
   assign samp_now = tq && seg == SEG_ONE && qcnt == seg1_len - 5'h01
                     && !(edge_dom && qcnt != 5'h00 && qcnt <= {2'h0, sjw_len});
   assign tx_now   = tq && seg == SEG_SYNC;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_bit        <= 1'b1;
         rx_bit_strobe <= 1'b0;
         tx_point      <= 1'b0;
      end else begin
         rx_bit_strobe <= samp_now;
         tx_point      <= tx_now;
         if (samp_now) begin
            rx_bit <= maj;
         end
      end
   end

   // transmit pin: recessive at once outside normal or in listen-only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         transmit_pin <= 1'b1;
      end else if (!run || ctrl1[C1_LISTN] || pwrdn_req) begin
         transmit_pin <= 1'b1;
      end else if (tx_now) begin
         transmit_pin <= tx_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // axi4-lite slave; write address and data may arrive in any order
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              do_wr;
   logic              acc_ok;
   assign do_wr  = aw_held && w_held && !s_axi_bvalid;
   // power-down stops the register clock, so accesses are refused
   assign acc_ok = (mode != CBT_PWRDN);

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] ofs);
      hit = (a[ADDR_W-1:2] == ADDR_W'(ofs) >> 2);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_wr) begin
            w_held <= 1'b0;
         end
      end
   end

   // ready flops: each channel takes one item then waits for the reply
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                          && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready)
                          && !s_axi_bvalid;
      end
   end

   logic known_wr;
   assign known_wr = hit(aw_addr, OFS_CTRL0) || hit(aw_addr, OFS_CTRL1)
                  || hit(aw_addr, OFS_BTR0) || hit(aw_addr, OFS_BTR1)
                  || hit(aw_addr, OFS_STATUS);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (known_wr && acc_ok) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register writes; timing may change at any time, compliance is software's
   logic wr_ok;
   assign wr_ok    = do_wr && acc_ok && w_strb[0];
   assign wake_clr = wr_ok && hit(aw_addr, OFS_STATUS) && w_data[ST_WAKE];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0      <= RST_CTRL0;
         ctrl1      <= RST_CTRL1;
         btr0       <= RST_BTR0;
         btr1       <= RST_BTR1;
         ena_locked <= 1'b0;
      end else begin
         if (wr_ok && hit(aw_addr, OFS_CTRL0)) begin
            ctrl0 <= w_data[3:0];
         end
         // later assignment wins: a wake clears the request but keeps the other bits
         if (wake_hit) begin
            ctrl0[C0_SLEEP_REQUEST] <= 1'b0; // bus activity wakes the node
         end
         if (wr_ok && hit(aw_addr, OFS_CTRL1)) begin
            ctrl1[2:1] <= w_data[2:1];
            if (!ena_locked) begin
               ctrl1[C1_ENA] <= w_data[C1_ENA];
               ena_locked    <= 1'b1;
            end
         end
         if (wr_ok && hit(aw_addr, OFS_BTR0)) begin
            btr0 <= w_data[7:0];
         end
         if (wr_ok && hit(aw_addr, OFS_BTR1)) begin
            btr1 <= w_data[7:0];
         end
      end
   end

   // read channel: answer one cycle after the address is taken
   logic [31:0] rd_mux;
   logic        rd_known;
   always_comb begin
      rd_mux   = 32'h0000_0000;
      rd_known = 1'b1;
      if (hit(s_axi_araddr, OFS_CTRL0)) begin
         rd_mux[3:0] = ctrl0;
      end else if (hit(s_axi_araddr, OFS_CTRL1)) begin
         rd_mux[2:0] = ctrl1;
      end else if (hit(s_axi_araddr, OFS_BTR0)) begin
         rd_mux[7:0] = btr0;
      end else if (hit(s_axi_araddr, OFS_BTR1)) begin
         rd_mux[7:0] = btr1;
      end else if (hit(s_axi_araddr, OFS_STATUS)) begin
         rd_mux[ST_SLEEP_ACKNOWLEDGE]        = sleep_ack;
         rd_mux[ST_WAKE]         = wake_flag;
         rd_mux[ST_MODE +: 2]    = mode;
      end else begin
         rd_known = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= acc_ok ? rd_mux : 32'h0000_0000;
            s_axi_rresp  <= (rd_known && acc_ok) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   a_disabled_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl1[C1_ENA] |=> mode == CBT_DISABLED)
      else $error("mode not disabled while enable low");
   a_pwrdn_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl1[C1_ENA] && stop_s[1] |=> mode == CBT_PWRDN)
      else $error("stop did not force power-down");
   a_pwrdn_wait: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl1[C1_ENA] && wait_s[1] && csw_s[1] |=> mode == CBT_PWRDN)
      else $error("wait with stop-in-wait not power-down");
   a_pwrdn_exit: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == CBT_PWRDN && ctrl1[C1_ENA] && !pwrdn_req |=> mode == CBT_NORMAL)
      else $error("power-down exit not to normal");
   a_tx_recessive: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl1[C1_LISTN] || pwrdn_req) |=> transmit_pin)
      else $error("transmit pin dominant in listen-only or power-down");
   a_irq_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
      wakeup_irq |-> $past(mode) == CBT_SLEEP && $past(ctrl0[C0_WAKEUP_IRQ_ENABLE]))
      else $error("wake irq outside sleep or masked");
   a_sync_one_tq: assert property (@(posedge aclk) disable iff (!aresetn)
      tq && seg == SEG_SYNC && run |=> seg == SEG_ONE && qcnt == 5'h00)
      else $error("sync segment longer than one quantum");
   a_ena_once: assert property (@(posedge aclk) disable iff (!aresetn)
      ena_locked |=> $stable(ctrl1[C1_ENA]))
      else $error("enable bit changed after first write");
   a_seg2_len: assert property (@(posedge aclk) disable iff (!aresetn)
      seg == SEG_TWO |-> qcnt < {1'b0, seg2_len})
      else $error("segment two overran its length");
   a_sleep_ack: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(sleep_ack) |-> $past(slp_s[1]) && !$past(frame_active))
      else $error("sleep acknowledged without request or idle bus");

   c_sample: cover property (@(posedge aclk) rx_bit_strobe);
   c_sleep: cover property (@(posedge aclk) mode == CBT_SLEEP ##1 wakeup_irq);
   c_pwrdn: cover property (@(posedge aclk) mode == CBT_PWRDN ##1 mode == CBT_NORMAL);
endmodule // cbt_core

// >>> src/cbt_pkg.sv
// cbt_pkg: register map, field layout, reset values and modes of the
// can bit timing and power mode block.
// assumes a 32-bit axi4-lite register bus; one register per aligned word.
package cbt_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL0  = 8'h00;
   localparam logic [7:0] OFS_CTRL1  = 8'h04;
   localparam logic [7:0] OFS_BTR0   = 8'h08;
   localparam logic [7:0] OFS_BTR1   = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // control_reg_zero fields
   localparam int C0_SLEEP_REQUEST = 0;
   localparam int C0_WAKEUP_ENABLE  = 1;
   localparam int C0_STOP_IN_WAIT = 2;
   localparam int C0_WAKEUP_IRQ_ENABLE = 3;
   // control_reg_one fields
   localparam int C1_ENA   = 0;
   localparam int C1_CLKS  = 1;
   localparam int C1_LISTN = 2;
   // bit_timing_reg_zero fields
   localparam int B0_PRE   = 0;
   localparam int B0_PRE_W = 6;
   localparam int B0_SJW   = 6;
   // bit_timing_reg_one fields
   localparam int B1_SEG1  = 0;
   localparam int B1_SEG2  = 4;
   localparam int B1_SAMP3 = 7;
   // status fields
   localparam int ST_SLEEP_ACKNOWLEDGE = 0;
   localparam int ST_WAKE  = 1;
   localparam int ST_MODE  = 4;
   // reset values
   localparam logic [3:0] RST_CTRL0 = 4'h0;
   localparam logic [2:0] RST_CTRL1 = 3'h0;
   localparam logic [7:0] RST_BTR0  = 8'h00;
   localparam logic [7:0] RST_BTR1  = 8'h23;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // module operating modes
   typedef enum logic [1:0] {
      CBT_DISABLED = 2'b00,
      CBT_NORMAL   = 2'b01,
      CBT_SLEEP    = 2'b10,
      CBT_PWRDN    = 2'b11
   } cbt_mode_e;
   // bit time segments
   typedef enum logic [1:0] {
      SEG_SYNC = 2'b00,
      SEG_ONE  = 2'b01,
      SEG_TWO  = 2'b10
   } cbt_seg_e;
endpackage

// >>> tb/cbt_bus_node.sv
// cbt_bus_node: the other nodes of the can bus, seen through a transceiver.
// assumes 0 is dominant on both pins; dom is commanded by the bench.
`timescale 1ns/1ps
module cbt_bus_node (
   input  wire logic transmit_pin,
   input  wire logic dom,
   output logic      can_rx
);
   // wired-and bus with a recessive pull-up, so our own dominant bits come back
   assign can_rx = transmit_pin & ~dom;
endmodule // cbt_bus_node

// >>> tb/tb_can_bit_timing_power_modes.sv
// tb_can_bit_timing_power_modes: register and bit timing tests of cbt_core.
// assumes cbt_bus_node closes the bus; frame_act stands in for the protocol logic.
`timescale 1ns/1ps
module tb_can_bit_timing_power_modes;
   import cbt_pkg::*;
   logic        aclk = 0, aresetn = 0, osc_clk = 0, dom = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        cpu_wait = 0, cpu_stop = 0, tx_data = 1, frame_act = 0;
   logic [3:0]  wstrb = 4'hF;
   int          mismatches = 0, n_checks = 0, cyc = 0;
   wire         awready, wready, bvalid, arready, rvalid, can_rx, transmit_pin;
   wire         rx_bit, rx_bit_strobe, tx_point, wakeup_irq;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   cbt_mode_e   mode;

   cbt_core cbt_core_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .osc_clk(osc_clk), .cpu_wait(cpu_wait),
      .cpu_stop(cpu_stop), .can_rx(can_rx), .transmit_pin(transmit_pin),
      .tx_data(tx_data), .frame_active(frame_act), .rx_bit(rx_bit),
      .rx_bit_strobe(rx_bit_strobe), .tx_point(tx_point),
      .wakeup_irq(wakeup_irq), .mode(mode));
   cbt_bus_node cbt_bus_node_inst (.transmit_pin(transmit_pin), .dom(dom), .can_rx(can_rx));

   ////////////////////////////////////////////////////////////////////////////
   always #20 aclk = ~aclk;
   // oscillator at a third of the bus rate, phase kept off the bus clock edges
   initial begin
      #7;
      forever #60 osc_clk = ~osc_clk;
   end
   // a hang ends the run as a mismatch
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         print_verdict;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // each channel released at its own handshake; entered just after an edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic pa, pw;
      pa = 1;
      pw = 1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (pa | pw) begin
         @(posedge aclk);
         if (pa && awready === 1'b1) begin
            pa = 0;
            awvalid <= 1'h0;
         end
         if (pw && wready === 1'b1) begin
            pw = 0;
            wvalid <= 1'h0;
         end
      end
      bready <= 1'h1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'h0;
      chk("bresp", 32'(r), 32'(bresp));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'h0;
      rready <= 1'h1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'h0;
      chk("rresp", 32'(r), 32'(rresp));
      chk("rdata", d, rdata);
   endtask
   task automatic wm(input cbt_mode_e m);
      repeat (300) if (mode !== m) @(posedge aclk);
      chk("mode", 32'(m), 32'(mode));
   endtask
   // pin level at a transmit point, then cycles to the next one
   task automatic per(input logic [31:0] n, input logic p);
      logic [31:0] c;
      c = 0;
      do @(posedge aclk); while (tx_point !== 1'b1);
      chk("tx_pin", 32'(p), 32'(transmit_pin));
      do begin
         @(posedge aclk);
         c++;
      end while (tx_point !== 1'b1);
      chk("bit_time", n, c);
   endtask
   task automatic rxc(input logic b);
      do @(posedge aclk); while (rx_bit_strobe !== 1'b1);
      chk("rx_bit", 32'(b), 32'(rx_bit));
   endtask
   task automatic print_verdict;
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // config changes mid-bit spoil one period, so two transmit points are skipped
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      rd(OFS_STATUS, 32'h0, RESP_OKAY);
      rd(OFS_BTR1, 32'h23, RESP_OKAY);
      rd(8'h14, 32'h0, RESP_SLVERR);
      wr(OFS_BTR1, 32'h13, RESP_OKAY);
      wr(OFS_CTRL1, 32'h3, RESP_OKAY);
      wm(CBT_NORMAL);
      tx_data <= 1'h0;
      per(32'h7, 1'h0);
      rxc(1'h0);
      wr(OFS_CTRL1, 32'h2, RESP_OKAY);
      rd(OFS_CTRL1, 32'h3, RESP_OKAY);
      wr(OFS_BTR0, 32'h41, RESP_OKAY);
      rd(OFS_BTR0, 32'h41, RESP_OKAY);
      wstrb <= 4'h0;
      wr(OFS_BTR0, 32'h0, RESP_OKAY);
      wstrb <= 4'hF;
      rd(OFS_BTR0, 32'h41, RESP_OKAY);
      repeat (2) @(posedge tx_point);
      per(32'hE, 1'h0);
      wr(OFS_CTRL0, 32'h4, RESP_OKAY);
      cpu_wait <= 1'h1;
      wm(CBT_PWRDN);
      chk("tx_pin", 32'h1, 32'(transmit_pin));
      rd(OFS_BTR1, 32'h0, RESP_SLVERR);
      cpu_wait <= 1'h0;
      wm(CBT_NORMAL);
      cpu_stop <= 1'h1;
      wm(CBT_PWRDN);
      cpu_stop <= 1'h0;
      wm(CBT_NORMAL);
      wr(OFS_CTRL0, 32'h0, RESP_OKAY);
      cpu_wait <= 1'h1;
      per(32'hE, 1'h0);
      cpu_wait <= 1'h0;
      wr(OFS_BTR0, 32'hC0, RESP_OKAY);
      wr(OFS_BTR1, 32'hFF, RESP_OKAY);
      wr(OFS_CTRL1, 32'h7, RESP_OKAY);
      repeat (2) @(posedge tx_point);
      per(32'h19, 1'h1);
      rxc(1'h0);
      tx_data <= 1'h1;
      dom <= 1'h1;
      repeat (2) @(posedge rx_bit_strobe);
      rxc(1'h0);
      dom <= 1'h0;
      repeat (2) @(posedge rx_bit_strobe);
      rxc(1'h1);
      wr(OFS_CTRL1, 32'h5, RESP_OKAY);
      repeat (2) @(posedge tx_point);
      per(32'h4B, 1'h1);
      frame_act <= 1'h1;
      wr(OFS_CTRL0, 32'hB, RESP_OKAY);
      repeat (8) @(posedge aclk);
      rd(OFS_STATUS, 32'h10, RESP_OKAY);
      frame_act <= 1'h0;
      wm(CBT_SLEEP);
      rd(OFS_STATUS, 32'h21, RESP_OKAY);
      chk("wake_irq", 32'h0, 32'(wakeup_irq));
      dom <= 1'h1;
      repeat (300) if (wakeup_irq !== 1'b1) @(posedge aclk);
      chk("wake_irq", 32'h1, 32'(wakeup_irq));
      dom <= 1'h0;
      wm(CBT_NORMAL);
      rd(OFS_STATUS, 32'h12, RESP_OKAY);
      wr(OFS_STATUS, 32'h2, RESP_OKAY);
      rd(OFS_STATUS, 32'h10, RESP_OKAY);
      print_verdict;
   end
endmodule // tb_can_bit_timing_power_modes
